// ===== core/irq_mask_pkg.sv
// Purpose: constants for the interrupt mask and stop control block
// Assumes: 32-bit mask word, high half in bits 31..16
// Notes: bit positions are word-absolute
package irq_mask_pkg;
    localparam int MASK_W = 32;
    localparam logic [31:0] MASK_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_USED = 32'hFFFF_7FFF;
    // high word
    localparam int BIT_BUS_IRQ_SLOT = 31;
    localparam int BIT_BUS_IRQ_E = 30;
    localparam int BIT_BUS_IRQ_F = 29;
    localparam int BIT_BUS_IRQ_G = 28;
    localparam int BIT_TIMED_IRQ_COLLISION = 27;
    localparam int BIT_TIMED_INTERRUPT = 26;
    localparam int BIT_PROCESS_INTERRUPT = 25;
    localparam int BIT_BUS_LOCK_FAULT = 24;
    localparam int BIT_IO_NOT_READY = 23;
    localparam int BIT_COORDINATOR_HALT = 22;
    localparam int BIT_SINGLE_STEP = 21;
    localparam int BIT_ADDRESS_COMPARE_ACTIVE = 20;
    localparam int BIT_COPROC_IRQ = 19;
    localparam int BIT_COPROC_CLOCK_LOSS = 18;
    localparam int BIT_STUCK_READY_MEMORY = 17;
    localparam int BIT_BRACKET_COUNT_OVERFLOW = 16;
    // low word, bit 15 unused
    localparam int BIT_MISSING_BLOCK = 14;
    localparam int BIT_MISSING_DATA_BLOCK = 13;
    localparam int BIT_SOFT_HALT_EVENT = 12;
    localparam int BIT_TRANSFER_LOAD_FAULT = 11;
    localparam int BIT_SUBSTITUTION_FAULT = 10;
    localparam int BIT_BLOCK_STACK_OVERFLOW = 9;
    localparam int BIT_INTERRUPT_STACK_OVERFLOW = 8;
    localparam int BIT_POWER_FAILURE = 7;
    localparam int BIT_DELAYED_CLOCK_INTERRUPT = 6;
    localparam int BIT_ACCESS_TIMEOUT = 5;
    localparam int BIT_ADDRESSING_FAULT = 4;
    localparam int BIT_PARITY_FAULT = 3;
    localparam int BIT_CYCLE_OVERRUN = 2;
    localparam int BIT_MODE_SWITCH_HALT = 1;
    localparam int BIT_COPROC_DMA_REQUEST = 0;
    typedef enum logic [1:0] {RUN, SOFT_STOP, HARD_STOP} run_state_e;
endpackage

// ===== core/irq_mask_ctrl.sv
// Purpose: interrupt event mask, pending latch and halt control of the cpu core
// Assumes: one op strobe at a time; events are same-clock pulses; backplane lines are async
// Notes: hard stop is left only by rst_n, which models power-down/up
//
// Notes on behaviour
// - the soft-halt operation moves the cpu at once into soft stop and no operation but hard halt follows.
// - the hard-halt operation enters hard stop, which only a power cycle can leave.
// - the mask-write operation copies bits 31..16 and 14..0 of the first work register into the mask; bit 15 stays 0.
// - the mask-read operation loads the 32-bit mask into the first work register.
// - an event with its mask bit cleared stays pending and interrupts nothing until cycle end.
// - a mask bit of 0 disables its event and a 1 enables it.
// - high mask word bits 15..0 hold slot bus irq down to bracket count overflow.
// - low mask word bit 15 is unused and bits 14..0 hold missing block down to coproc dma.
// - the slot bus irq bit is one shared position for whichever of lines a..d the slot has.
`timescale 1ns/10ps
module irq_mask_ctrl
    import irq_mask_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic mask_write_op,
    input wire logic mask_read_op,
    input wire logic soft_halt_op,
    input wire logic hard_halt_op,
    input wire logic cycle_end,
    input wire logic irq_ack,
    input wire logic [31:0] first_work_register,
    input wire logic [3:0] bus_irq_abcd,
    input wire logic [1:0] slot_line_sel,
    input wire logic [31:0] event_in,
    output logic [31:0] work_register_load,
    output logic work_register_load_en,
    output logic [31:0] interrupt_event_mask,
    output logic [31:0] pending_events,
    output logic irq_request,
    output logic [4:0] irq_vector,
    output logic exec_enable,
    output logic soft_stopped,
    output logic hard_stopped
);
    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] pend;
        logic [31:0] rdata;
        logic rvalid;
        logic unmask_all;
        logic [3:0] bsync1;
        logic [3:0] bsync2;
        logic [3:0] bsync3;
        logic [3:0] bline;
        run_state_e state;
    } state_s;

    state_s q, d;

    // highest set bit wins; bit 31 has top priority
    function automatic logic [4:0] top_bit(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    logic [31:0] ev;
    logic [31:0] eff;
    logic [31:0] ack_clr;
    logic [3:0] agree;

    always_comb begin
        ev = event_in & MASK_USED;
        // backplane lines are asynchronous: a level counts only once two stages agree,
        // so a one-cycle glitch never reaches the slot position
        agree = ~(q.bsync2 ^ q.bsync3);
        ev[BIT_BUS_IRQ_SLOT] = q.bline[slot_line_sel];
        eff = q.unmask_all ? 32'hFFFF_FFFF : q.mask;
        d = q;
        d.rvalid = 1'b0;
        d.bsync1 = bus_irq_abcd;
        d.bsync2 = q.bsync1;
        d.bsync3 = q.bsync2;
        d.bline = (agree & q.bsync3) | (~agree & q.bline);
        // ack only clears what is really requested, so a stray ack cannot drop bit 0
        ack_clr = 32'h0000_0000;
        if (irq_ack && q.state == RUN && (q.pend & eff) != 32'h0000_0000) begin
            ack_clr = 32'h0000_0001 << top_bit(q.pend & eff);
        end
        // events always latch, even with the bit masked; ack clears, new event wins
        d.pend = (q.pend & ~ack_clr) | ev;
        if (cycle_end) begin
            d.unmask_all = 1'b1;
        end else if (q.pend == 32'h0000_0000) begin
            d.unmask_all = 1'b0;
        end
        case (q.state)
            RUN: begin
                if (hard_halt_op) begin
                    d.state = HARD_STOP;
                end else if (soft_halt_op) begin
                    d.state = SOFT_STOP;
                end else if (mask_write_op) begin
                    d.mask = first_work_register & MASK_USED;
                    d.unmask_all = 1'b0;
                end else if (mask_read_op) begin
                    d.rdata = q.mask;
                    d.rvalid = 1'b1;
                end
            end
            SOFT_STOP: begin
                if (hard_halt_op) begin
                    d.state = HARD_STOP;
                end
            end
            HARD_STOP: d.state = HARD_STOP;
            default: d.state = RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{mask: MASK_RESET & MASK_USED, pend: 32'h0, rdata: 32'h0,
                   rvalid: 1'b0, unmask_all: 1'b0, bsync1: 4'h0, bsync2: 4'h0,
                   bsync3: 4'h0, bline: 4'h0, state: RUN};
        end else begin
            q <= d;
        end
    end

    // ops are fenced combinationally so nothing runs in the halting cycle itself
    assign exec_enable = (q.state == RUN) && !soft_halt_op && !hard_halt_op;
    assign soft_stopped = (q.state == SOFT_STOP);
    assign hard_stopped = (q.state == HARD_STOP);
    assign interrupt_event_mask = q.mask;
    assign pending_events = q.pend;
    assign work_register_load = q.rdata;
    assign work_register_load_en = q.rvalid;
    assign irq_request = ((q.pend & eff) != 32'h0) && (q.state == RUN);
    assign irq_vector = top_bit(q.pend & eff);

    property p_soft;
        @(posedge sys_clk) disable iff (!rst_n)
        (q.state == RUN && soft_halt_op && !hard_halt_op) |=> soft_stopped && !exec_enable;
    endproperty
    a_soft: assert property (p_soft) else $error("soft halt not entered");

    property p_hard;
        @(posedge sys_clk) disable iff (!rst_n)
        hard_stopped |=> hard_stopped && !irq_request;
    endproperty
    a_hard: assert property (p_hard) else $error("hard stop left");

    property p_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (exec_enable && mask_write_op)
            |=> interrupt_event_mask == ($past(first_work_register) & MASK_USED);
    endproperty
    a_write: assert property (p_write) else $error("mask write wrong");

    sequence s_read;
        exec_enable && mask_read_op && !mask_write_op;
    endsequence
    property p_read;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read |=> work_register_load_en && work_register_load == $past(interrupt_event_mask);
    endproperty
    a_read: assert property (p_read) else $error("mask read wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (event_in[BIT_PARITY_FAULT] && !irq_ack) |=> pending_events[BIT_PARITY_FAULT];
    endproperty
    a_hold: assert property (p_hold) else $error("event not latched");

    property p_gate;
        @(posedge sys_clk) disable iff (!rst_n)
        (!q.unmask_all && (pending_events & interrupt_event_mask) == 32'h0) |-> !irq_request;
    endproperty
    a_gate: assert property (p_gate) else $error("masked event interrupted");

    property p_unused;
        @(posedge sys_clk) disable iff (!rst_n)
        !interrupt_event_mask[15] && !pending_events[15];
    endproperty
    a_unused: assert property (p_unused) else $error("bit 15 set");

    property p_slot;
        @(posedge sys_clk) disable iff (!rst_n)
        q.bline[slot_line_sel] |=> pending_events[BIT_BUS_IRQ_SLOT];
    endproperty
    a_slot: assert property (p_slot) else $error("slot irq lost");

    property p_end;
        @(posedge sys_clk) disable iff (!rst_n)
        (cycle_end && pending_events != 32'h0 && !irq_ack && exec_enable && !mask_write_op)
            |=> irq_request;
    endproperty
    a_end: assert property (p_end) else $error("pending not released");

    sequence s_agree;
        q.bsync2 == q.bsync3;
    endsequence
    property p_sync;
        @(posedge sys_clk) disable iff (!rst_n)
        s_agree |=> q.bline == $past(q.bsync3);
    endproperty
    a_sync: assert property (p_sync) else $error("backplane line not taken");

    property p_vec;
        @(posedge sys_clk) disable iff (!rst_n)
        irq_request |-> ((q.pend & eff) >> irq_vector) == 32'h0000_0001;
    endproperty
    a_vec: assert property (p_vec) else $error("vector not highest");

    property p_ack;
        @(posedge sys_clk) disable iff (!rst_n)
        (irq_ack && !irq_request && ev == 32'h0000_0000) |=> $stable(pending_events);
    endproperty
    a_ack: assert property (p_ack) else $error("stray ack cleared pending");

    property p_hard_in;
        @(posedge sys_clk) disable iff (!rst_n)
        (hard_halt_op && !hard_stopped) |=> hard_stopped && !soft_stopped;
    endproperty
    a_hard_in: assert property (p_hard_in) else $error("hard stop not entered");

    property p_frozen;
        @(posedge sys_clk) disable iff (!rst_n)
        (soft_stopped || hard_stopped) |=> $stable(interrupt_event_mask) && !work_register_load_en;
    endproperty
    a_frozen: assert property (p_frozen) else $error("operation ran while stopped");
endmodule

// ===== tb/interrupt_mask_and_stop_control_tb_top.sv
// Purpose: self-checking bench for the interrupt mask and stop control block
// Assumes: inputs change 10 ns after the rising edge; outputs read there too
// Notes: rst_n stands in for the power cycle that alone leaves the stop states
`timescale 1ns/10ps
module interrupt_mask_and_stop_control_tb_top;
    import irq_mask_pkg::*;
    logic sys_clk = 0, rst_n = 0, mask_write_op = 0, mask_read_op = 0, soft_halt_op = 0;
    logic hard_halt_op = 0, cycle_end = 0, irq_ack = 0, work_register_load_en, irq_request;
    logic exec_enable, soft_stopped, hard_stopped;
    logic [31:0] first_work_register = 0, event_in = 0, lfsr = 32'h61ACB667, v;
    logic [31:0] work_register_load, interrupt_event_mask, pending_events;
    logic [3:0] bus_irq_abcd = 0;
    logic [1:0] slot_line_sel = 0;
    logic [4:0] irq_vector;
    int err_count = 0, checks_done = 0;
    irq_mask_ctrl i_irq_mask_ctrl (.sys_clk, .rst_n, .mask_write_op, .mask_read_op,
        .soft_halt_op, .hard_halt_op, .cycle_end, .irq_ack, .first_work_register,
        .bus_irq_abcd, .slot_line_sel, .event_in, .work_register_load, .work_register_load_en,
        .interrupt_event_mask, .pending_events, .irq_request, .irq_vector, .exec_enable,
        .soft_stopped, .hard_stopped);
    always #50 sys_clk = ~sys_clk;
    function logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick();
        s = 0;
    endtask
    task automatic rst();
        rst_n = 0;
        tick(20);
        rst_n = 1;
    endtask
    task automatic wr_mask(input logic [31:0] m);
        first_work_register = m;
        pulse(mask_write_op);
    endtask
    // one event pulse, then a cycle for the pending latch to land
    task automatic raise(input int b);
        event_in[b] = 1'b1;
        tick();
        event_in = '0;
        tick();
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    int bits[3] = '{BIT_TIMED_INTERRUPT, BIT_PARITY_FAULT, BIT_COPROC_DMA_REQUEST};
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
    initial begin
        rst();
        chk(interrupt_event_mask, MASK_USED);
        chk(32'({exec_enable, irq_request}), 32'h2);
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : lfsr;
            lfsr = nxt(lfsr);
            wr_mask(v);
            chk(interrupt_event_mask, v & MASK_USED);
            pulse(mask_read_op);
            chk(32'(work_register_load_en), 32'h1);
            chk(work_register_load, v & MASK_USED);
        end
        foreach (bits[k]) begin
            rst();
            wr_mask(~(32'h1 << bits[k]));
            raise(bits[k]);
            chk(pending_events, 32'h1 << bits[k]);
            chk(32'(irq_request), 32'h0);
            pulse(irq_ack);
            chk(pending_events, 32'h1 << bits[k]);
            pulse(cycle_end);
            tick();
            chk(32'({irq_request, irq_vector}), 32'h20 | bits[k]);
            pulse(irq_ack);
            chk(pending_events, 32'h0);
            raise(bits[k]);
            chk(32'(irq_request), 32'h0);
            wr_mask(32'h1 << bits[k]);
            tick();
            chk(32'({irq_request, irq_vector}), 32'h20 | bits[k]);
        end
        // two held events come out highest bit first once the cycle ends
        rst();
        wr_mask(32'h0);
        event_in = (32'h1 << BIT_TIMED_INTERRUPT) | (32'h1 << BIT_PARITY_FAULT);
        tick();
        event_in = '0;
        pulse(cycle_end);
        chk(32'({irq_request, irq_vector}), 32'h20 | BIT_TIMED_INTERRUPT);
        pulse(irq_ack);
        chk(32'({irq_request, irq_vector}), 32'h20 | BIT_PARITY_FAULT);
        // only the selected backplane line may reach the shared slot position;
        // a one-cycle glitch on it is filtered by the synchroniser
        for (int s = 0; s < 4; s++) begin
            rst();
            slot_line_sel = 2'(s);
            bus_irq_abcd = 4'h1 << s;
            tick();
            bus_irq_abcd = ~(4'h1 << s);
            tick(6);
            chk(32'(pending_events[BIT_BUS_IRQ_SLOT]), 32'h0);
            bus_irq_abcd = 4'h1 << s;
            tick(6);
            bus_irq_abcd = 4'h0;
            chk(32'(pending_events[BIT_BUS_IRQ_SLOT]), 32'h1);
        end
        rst();
        soft_halt_op = 1;
        #1;
        chk(32'(exec_enable), 32'h0);
        tick();
        soft_halt_op = 0;
        chk(32'({soft_stopped, hard_stopped}), 32'h2);
        wr_mask(32'h0);
        chk(interrupt_event_mask, MASK_USED);
        pulse(hard_halt_op);
        chk(32'(hard_stopped), 32'h1);
        rst();
        chk(32'({exec_enable, hard_stopped}), 32'h2);
        first_work_register = 32'h0;
        hard_halt_op = 1;
        mask_write_op = 1;
        tick();
        {hard_halt_op, mask_write_op} = 2'b00;
        pulse(soft_halt_op);
        tick(5);
        chk(32'({hard_stopped, exec_enable}), 32'h2);
        chk(interrupt_event_mask, MASK_USED);
        finish_test();
    end
endmodule
